// ### pfc_cfg.svh
// Purpose: constants for the feature control register and phase detector
// Assumes: one 100 MHz clock, all pins sampled synchronously
// Notes:   bit positions of the feature control register
// Behaviour
// R1 - Each feature bit acts when one and is inert when zero.
// R2 - Software writes zero into the three reserved low bits.
// R3 - Bit 3 powers down all but the programming interface. The code only idles the detector and sets power_down_out.
// R4 - Bit 4 loads counter programming immediately and continuously.
// R5 - Bit 5 routes the modulus select signal to the diagnostic pin. The code routes the prescaler instead when bit 6 is also set.
// R6 - Bit 6 routes the raw prescaler output to the diagnostic pin.
// R7 - Bit 7 disables the divided VCO and divided reference outputs.
// R8 - The detector fires on rising edges of both divided signals.
// R9 - A leading divided VCO pulses the down output low.
// R10 - A leading divided reference pulses the up output low.
// R11 - Pulse width follows the phase offset between the two signals.
// R12 - Up raises and down lowers the VCO frequency via the loop filter.
// R13 - The integration pin carries the NAND of up and down.
// R14 - Lock indicator is the AND of up and down after integration.
// R15 - Feature functions apply only while the enable input is low.
// R16 - Parallel mode latches data on the rising write strobe edge.
// R17 - Serial mode shifts into a holding stage, updating on the falling edge.
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH
`define PFC_BIT_PWRDN   3
`define PFC_BIT_CLOAD   4
`define PFC_BIT_MSOUT   5
`define PFC_BIT_PSOUT   6
`define PFC_BIT_FOE     7
`define PFC_RESET_VAL   8'h00
`define PFC_LOCK_FILT   4
`endif

// ### pfc_pkg.sv
// Purpose: types for the feature control block
// Assumes: nothing
// Notes:   detector state
package pfc_pkg;
  typedef enum logic [1:0] {PFC_IDLE, PFC_UP, PFC_DOWN} pfc_pd_t;
endpackage

// ### pfc_top.sv
// Purpose: feature control register and phase-frequency detector
// Assumes: strobes and clocks synchronous to clock_in
// Notes:   outputs registered
`timescale 1ns/1ps
`default_nettype none
`include "pfc_cfg.svh"
module pfc_top (
  input  wire logic       clock_in,            // system clock
  input  wire logic       nrst_in,             // sync reset, low
  input  wire logic [7:0] data_in,             // parallel data
  input  wire logic       serial_mode_in,      // 1 serial, 0 parallel
  input  wire logic       feat_wr_in,          // feature write strobe
  input  wire logic       sclk_in,             // serial shift clock
  input  wire logic       sdata_in,            // serial data, msb first
  input  wire logic       feat_en_n_in,        // feature enable, low
  input  wire logic       fp_in,               // divided vco
  input  wire logic       fc_in,               // divided reference
  input  wire logic       modulus_select_in,   // prescaler modulus select
  input  wire logic       prescaler_in,        // raw prescaler output
  output logic            pump_up_n_out,       // up pulse, low
  output logic            pump_down_n_out,     // down pulse, low
  output logic            cext_out,            // integration pin
  output logic            lock_indicator_out,  // lock detect
  output logic            diag_out,            // diagnostic pin
  output logic            fp_out,              // gated divided vco
  output logic            fc_out,              // gated divided ref
  output logic            power_down_out,      // power down request
  output logic            counter_load_out     // continuous load
);
  import pfc_pkg::*;

  // ----------------------------------------
  // feature register loading
  // ----------------------------------------
  logic [7:0] feat_reg;
  logic [7:0] shift_reg;
  logic       wr_reg;
  logic       sclk_reg;
  logic [7:0] act;

  // strobe and shift clock edge history, follows the pins in reset so release brings no false edge
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      wr_reg   <= feat_wr_in;
      sclk_reg <= sclk_in;
    end else begin
      wr_reg   <= feat_wr_in;
      sclk_reg <= sclk_in;
    end
  end

  // serial holding stage, shifts while strobe high
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      shift_reg <= 8'h00;
    end else if (serial_mode_in && feat_wr_in && sclk_in && !sclk_reg) begin
      shift_reg <= {shift_reg[6:0], sdata_in}; // R17
    end
  end

  // active register update, kept alive through power down
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      feat_reg <= `PFC_RESET_VAL;
    end else if (!serial_mode_in && feat_wr_in && !wr_reg) begin
      feat_reg <= data_in; // R16 R3
    end else if (serial_mode_in && !feat_wr_in && wr_reg) begin
      feat_reg <= shift_reg; // R17
    end
  end

  // functions only while enable low; reserved bits unused
  assign act = feat_en_n_in ? 8'h00 : feat_reg; // R15 R1

  // ----------------------------------------
  // phase-frequency detector
  // ----------------------------------------
  pfc_pd_t pd_reg;
  logic    fp_reg;
  logic    fc_reg;
  logic    fp_rise;
  logic    fc_rise;

  assign fp_rise = fp_in && !fp_reg; // R8
  assign fc_rise = fc_in && !fc_reg; // R8

  // divided input edge history, follows the pins in reset so release brings no false edge
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      fp_reg <= fp_in;
      fc_reg <= fc_in;
    end else begin
      fp_reg <= fp_in;
      fc_reg <= fc_in;
    end
  end

  // tri-state detector: pulse lasts from leading to lagging edge
  always_ff @(posedge clock_in) begin
    if (!nrst_in || act[`PFC_BIT_PWRDN]) begin
      pd_reg <= PFC_IDLE; // R3
    end else begin
      case (pd_reg)
        PFC_IDLE: begin
          if (fp_rise && !fc_rise) begin
            pd_reg <= PFC_DOWN; // R9
          end else if (fc_rise && !fp_rise) begin
            pd_reg <= PFC_UP; // R10
          end
        end
        PFC_UP: begin
          if (fp_rise) begin
            pd_reg <= PFC_IDLE; // R11
          end
        end
        PFC_DOWN: begin
          if (fc_rise) begin
            pd_reg <= PFC_IDLE; // R11
          end
        end
        default: pd_reg <= PFC_IDLE;
      endcase
    end
  end

  // pump outputs, registered from detector state
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      pump_up_n_out   <= 1'b1;
      pump_down_n_out <= 1'b1;
      cext_out        <= 1'b0;
    end else begin
      pump_up_n_out   <= (pd_reg != PFC_UP);   // R10 R12
      pump_down_n_out <= (pd_reg != PFC_DOWN); // R9 R12
      cext_out        <= !((pd_reg != PFC_UP) && (pd_reg != PFC_DOWN)); // R13
    end
  end

  // lock integrator: quiet for several cycles means locked
  logic [2:0] quiet_reg;
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      quiet_reg          <= 3'h0;
      lock_indicator_out <= 1'b0;
    end else begin
      if (cext_out) begin
        quiet_reg <= 3'h0;
      end else if (quiet_reg != 3'(`PFC_LOCK_FILT)) begin
        quiet_reg <= quiet_reg + 3'h1;
      end
      lock_indicator_out <= (quiet_reg == 3'(`PFC_LOCK_FILT)) && !cext_out; // R14
    end
  end

  // ----------------------------------------
  // feature-driven outputs
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      diag_out         <= 1'b0;
      fp_out           <= 1'b0;
      fc_out           <= 1'b0;
      power_down_out   <= 1'b0;
      counter_load_out <= 1'b0;
    end else begin
      if (act[`PFC_BIT_PSOUT]) begin
        diag_out <= prescaler_in; // R6
      end else if (act[`PFC_BIT_MSOUT]) begin
        diag_out <= modulus_select_in; // R5
      end else begin
        diag_out <= 1'b0;
      end
      fp_out           <= act[`PFC_BIT_FOE] ? 1'b0 : fp_in; // R7
      fc_out           <= act[`PFC_BIT_FOE] ? 1'b0 : fc_in; // R7
      power_down_out   <= act[`PFC_BIT_PWRDN]; // R3
      counter_load_out <= act[`PFC_BIT_CLOAD]; // R4
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_down_on_lead: assert property (@(posedge clock_in) disable iff (!nrst_in) // R9
    (pd_reg == PFC_IDLE && fp_rise && !fc_rise && !act[`PFC_BIT_PWRDN]) |-> ##2 !pump_down_n_out)
    else $error("down pulse missing");
  a_up_on_lead: assert property (@(posedge clock_in) disable iff (!nrst_in) // R10
    (pd_reg == PFC_IDLE && fc_rise && !fp_rise && !act[`PFC_BIT_PWRDN]) |-> ##2 !pump_up_n_out)
    else $error("up pulse missing");
  a_pump_exclusive: assert property (@(posedge clock_in) disable iff (!nrst_in) // R12
    !(!pump_up_n_out && !pump_down_n_out))
    else $error("both pumps active");
  a_cext_nand: assert property (@(posedge clock_in) disable iff (!nrst_in) // R13
    cext_out == !(pump_up_n_out && pump_down_n_out))
    else $error("cext not nand of pumps");
  a_up_ends: assert property (@(posedge clock_in) disable iff (!nrst_in) // R11
    (pd_reg == PFC_UP && fp_rise && !act[`PFC_BIT_PWRDN]) |=> pd_reg == PFC_IDLE)
    else $error("up pulse not ended");
  a_par_latch: assert property (@(posedge clock_in) disable iff (!nrst_in) // R16
    (!serial_mode_in && feat_wr_in && !wr_reg) |=> feat_reg == $past(data_in))
    else $error("parallel latch failed");
  a_ser_update: assert property (@(posedge clock_in) disable iff (!nrst_in) // R17
    (serial_mode_in && !feat_wr_in && wr_reg) |=> feat_reg == $past(shift_reg))
    else $error("serial update failed");
  a_enable_gate: assert property (@(posedge clock_in) disable iff (!nrst_in) // R15
    feat_en_n_in |=> !power_down_out && !counter_load_out)
    else $error("feature active while disabled");
  a_oe_gate: assert property (@(posedge clock_in) disable iff (!nrst_in) // R7
    act[`PFC_BIT_FOE] |=> !fp_out && !fc_out)
    else $error("outputs not disabled");
  a_lock_quiet: assert property (@(posedge clock_in) disable iff (!nrst_in) // R14
    cext_out |=> !lock_indicator_out)
    else $error("lock during pump activity");
  a_pwrdn_idle: assert property (@(posedge clock_in) disable iff (!nrst_in) // R3
    act[`PFC_BIT_PWRDN] |-> ##2 (pump_up_n_out && pump_down_n_out))
    else $error("pump active in power down");
  a_load_follow: assert property (@(posedge clock_in) disable iff (!nrst_in) // R4
    act[`PFC_BIT_CLOAD] |=> counter_load_out)
    else $error("counter load not active");
  a_modulus_select_route: assert property (@(posedge clock_in) disable iff (!nrst_in) // R5
    (act[`PFC_BIT_MSOUT] && !act[`PFC_BIT_PSOUT]) |=> diag_out == $past(modulus_select_in))
    else $error("modulus select not routed");
  a_pre_route: assert property (@(posedge clock_in) disable iff (!nrst_in) // R6
    act[`PFC_BIT_PSOUT] |=> diag_out == $past(prescaler_in))
    else $error("prescaler not routed");
endmodule
`default_nettype wire

// ### pfc_vco_model.sv
// Purpose: loop filter and vco model on the detector outputs
// Assumes: pump pulses sampled on the system clock
// Notes:   a shorter half period is a higher vco frequency
`timescale 1ns/1ps
`default_nettype none
module pfc_vco_model (
  input  wire logic clock_in,   // system clock
  input  wire logic up_n_in,    // pump up, low
  input  wire logic down_n_in,  // pump down, low
  output logic      fp_out      // divided vco
);
  int   half_reg = 7;
  int   cnt_reg  = 0;
  logic up_reg   = 1'b1;
  logic dn_reg   = 1'b1;
  logic fp_reg   = 1'b0;
  assign fp_out = fp_reg;
  // steer the frequency at the end of each pump pulse, half period held between 2 and 12
  always_ff @(posedge clock_in) begin
    up_reg <= up_n_in;
    dn_reg <= down_n_in;
    if (up_n_in && !up_reg && half_reg > 2) begin
      half_reg <= half_reg - 1;
    end else if (down_n_in && !dn_reg && half_reg < 12) begin
      half_reg <= half_reg + 1;
    end
  end
  // toggle the divided output every half period
  always_ff @(posedge clock_in) begin
    cnt_reg <= (cnt_reg >= half_reg - 1) ? 0 : cnt_reg + 1;
    if (cnt_reg >= half_reg - 1) begin
      fp_reg <= !fp_reg;
    end
  end
endmodule
`default_nettype wire

// ### tb.sv
// Purpose: self-checking bench for the feature register and detector
// Assumes: inputs driven on the rising edge, outputs sampled on the falling
// Notes:   reset case first, then register rows, serial and detector cases
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {logic [7:0] d; logic en_n; logic [4:0] ex;} pfc_row_t;
  logic clock_in = 0, nrst_in = 0, serial_mode_in = 0, feat_wr_in = 0, sclk_in = 0;
  logic sdata_in = 0, feat_en_n_in = 0, fp_drv = 1, fc_in = 1, use_vco = 0;
  logic modulus_select_in = 1, prescaler_in = 0, lock_lo, fp_in, vco_fp;
  logic [7:0] data_in = 8'h00;
  logic pump_up_n_out, pump_down_n_out, cext_out, lock_indicator_out, diag_out;
  logic fp_out, fc_out, power_down_out, counter_load_out;
  int   n_errors = 0, n_compared = 0, w_up, w_dn, w_cx;
  pfc_row_t rows [7] = '{'{8'h00, 0, 5'h03}, '{8'h08, 0, 5'h10}, '{8'h10, 0, 5'h0B},
    '{8'h20, 0, 5'h07}, '{8'h60, 0, 5'h03}, '{8'h80, 0, 5'h00}, '{8'h30, 1, 5'h03}};
  assign fp_in = use_vco ? vco_fp : fp_drv;
  pfc_top uut (.clock_in(clock_in), .nrst_in(nrst_in), .data_in(data_in),
    .serial_mode_in(serial_mode_in), .feat_wr_in(feat_wr_in), .sclk_in(sclk_in),
    .sdata_in(sdata_in), .feat_en_n_in(feat_en_n_in), .fp_in(fp_in), .fc_in(fc_in),
    .modulus_select_in(modulus_select_in), .prescaler_in(prescaler_in),
    .pump_up_n_out(pump_up_n_out), .pump_down_n_out(pump_down_n_out), .cext_out(cext_out),
    .lock_indicator_out(lock_indicator_out), .diag_out(diag_out), .fp_out(fp_out),
    .fc_out(fc_out), .power_down_out(power_down_out), .counter_load_out(counter_load_out));
  pfc_vco_model vco (.clock_in(clock_in), .up_n_in(pump_up_n_out),
    .down_n_in(pump_down_n_out), .fp_out(vco_fp));
  initial begin
    forever #5 clock_in = ~clock_in;
  end
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic wr_par(logic [7:0] d);
    data_in <= d;
    cyc(1);
    feat_wr_in <= 1;
    cyc(1);
    feat_wr_in <= 0;
    cyc(3);
  endtask
  // lead edge, lag edge off cycles later, count the pulse widths
  task automatic pd_run(logic lead_fc, int off, int ew);
    fp_drv <= 0;
    fc_in  <= 0;
    cyc(3);
    if (lead_fc) fc_in <= 1; else fp_drv <= 1;
    {w_up, w_dn, w_cx, lock_lo} = 0;
    for (int i = 0; i < off + 12; i++) begin
      if (i == off) begin
        if (lead_fc) fp_drv <= 1; else fc_in <= 1;
      end
      @(negedge clock_in);
      w_up += !pump_up_n_out;
      w_dn += !pump_down_n_out;
      w_cx += cext_out;
      lock_lo |= !lock_indicator_out;
      @(posedge clock_in);
    end
    check(8'(w_up), lead_fc ? 8'(ew) : 8'h00);
    check(8'(w_dn), lead_fc ? 8'h00 : 8'(ew));
    check(8'(w_cx), 8'(ew));
    check({lock_lo, lock_indicator_out}, {ew > 0, 1'b1});
    $display("detector case done, offset %0d", off);
  endtask
  initial begin
    logic [7:0] sv;
    cyc(5);
    @(negedge clock_in);
    check({pump_up_n_out, pump_down_n_out, cext_out, power_down_out, counter_load_out,
      diag_out, fp_out, fc_out}, 8'hC0);
    $display("reset case done");
    @(posedge clock_in);
    nrst_in <= 1;
    cyc(1);
    foreach (rows[k]) begin
      feat_en_n_in <= rows[k].en_n;
      wr_par(rows[k].d);
      @(negedge clock_in);
      check({power_down_out, counter_load_out, diag_out, fp_out & !rows[k].d[3],
        fc_out & !rows[k].d[3]}, rows[k].ex);
      @(posedge clock_in);
    end
    $display("register table done");
    feat_en_n_in <= 0;
    prescaler_in <= 1;
    modulus_select_in <= 0;
    wr_par(8'h60);
    @(negedge clock_in);
    check(diag_out, 8'h01);
    @(posedge clock_in);
    prescaler_in <= 0;
    modulus_select_in <= 1;
    wr_par(8'h30);
    $display("prescaler route case done");
    serial_mode_in <= 1;
    feat_wr_in <= 1;
    sv = 8'h90;
    for (int b = 7; b >= 0; b--) begin
      sdata_in <= sv[b];
      cyc(1);
      sclk_in <= 1;
      cyc(1);
      sclk_in <= 0;
      cyc(1);
    end
    @(negedge clock_in);
    check({power_down_out, counter_load_out, diag_out, fp_out, fc_out}, 8'h0F);
    @(posedge clock_in);
    feat_wr_in <= 0;
    cyc(3);
    @(negedge clock_in);
    check({power_down_out, counter_load_out, diag_out, fp_out, fc_out}, 8'h08);
    $display("serial case done");
    @(posedge clock_in);
    serial_mode_in <= 0;
    wr_par(8'h00);
    for (int off = 0; off < 6; off += 2) begin
      pd_run(1'b1, off, off);
      pd_run(1'b0, off, off);
    end
    wr_par(8'h08);
    pd_run(1'b1, 3, 0);
    wr_par(8'h00);
    use_vco <= 1;
    repeat (60) begin
      fc_in <= !fc_in;
      cyc(4);
    end
    check({7'h00, vco.half_reg < 7}, 8'h01);
    $display("loop case done");
    wr_par(8'h18);
    @(negedge clock_in);
    check({power_down_out, counter_load_out}, 8'h03);
    @(posedge clock_in);
    nrst_in <= 0;
    cyc(1);
    nrst_in <= 1;
    cyc(1);
    @(negedge clock_in);
    check({power_down_out, counter_load_out}, 8'h00);
    $display("mid-run reset case done");
    end_of_test();
  end
endmodule
`default_nettype wire
